//--- hdl/ebh_arbiter.sv
// external bus hold arbiter with idle control register
// assumes avalon-mm master on i_clk_sys and requesters on same clock
// Function
// - idle control register is 16-bit read/write, resets to AAAA hex.
// - no idle state for internal rom, ram or peripheral areas.
// - hold pins act only while their port pins are in control mode.
// - on hold request, float the bus then assert acknowledge low.
// - request high releases hold; device drives bus again.
// - cpu runs internally during hold, stalls at external access. Here no request of any region is granted during hold.
// - no hold between partial accesses of a split 16-bit cycle.
// - no hold between byte accesses of a word or halfword.
// - no hold between read and write of a read-modify-write.
// - in stop or idle mode hold is never entered.
// - in halt mode acknowledge follows the request directly.
// - priority: hold, dma, operand, branch fetch, sequential fetch.
// - instruction fetch may go between read and write of rmw.
// - no fetch nor hold between bus-size split accesses.
// - idle state follows last read state in either bus mode.
// - write cycles never get an idle state.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ebh_arbiter #(
    parameter int unsigned NUM_BLK = ebh_pkg::NUM_BLOCKS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [1:0] i_avs_byteenable,
    input wire logic [15:0] i_avs_writedata,
    output logic [15:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_avs_response_err,
    // hold pins
    input wire logic i_hold_request_n,
    output logic o_hold_acknowledge_n,
    output logic o_hold_acknowledge_oe,
    output logic o_bus_oe,
    // power state
    input wire logic i_pwr_stop_idle,
    input wire logic i_pwr_halt,
    // requesters: dma, operand, branch fetch, sequential fetch
    input wire logic [3:0] i_req,
    input wire logic [3:0] i_req_lock,
    input wire logic i_req_rmw_read,
    input wire logic i_req_read,
    input wire logic [1:0] i_req_region,
    input wire logic [1:0] i_req_block,
    output logic [3:0] o_gnt,
    output logic o_cycle_idle_state,
    // one-cycle pulse from the bus timing logic: access finished
    input wire logic i_cycle_done
);
    initial begin
        if (NUM_BLK != ebh_pkg::NUM_BLOCKS) begin
            $error("ebh_arbiter: NUM_BLK must be 4");
        end
    end

    ebh_sync_if hsync ();
    ebh_hold_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_hold_request_n(i_hold_request_n),
        .sync(hsync)
    );

    // registers
    logic [15:0] idle_ctrl_q;
    logic [15:0] idle_ctrl_d;
    logic [1:0] port_ctrl_q;
    logic [1:0] port_ctrl_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic err_q;
    logic err_d;
    ebh_pkg::ebh_state_e st_q;
    ebh_pkg::ebh_state_e st_d;
    logic [3:0] gnt_q;
    logic [3:0] gnt_d;
    logic lock_q;
    logic lock_d;
    logic rmw_q;
    logic rmw_d;
    logic idle_need_q;
    logic idle_need_d;

    function automatic logic [3:0] pick(input logic [3:0] req);
        logic [3:0] g;
        g = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
                g = 4'h0;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    logic pins_ctrl;
    logic hold_want;
    logic [15:0] status;
    logic acc;
    assign pins_ctrl = port_ctrl_q[ebh_pkg::PORT_HOLD_REQ_BIT]
        & port_ctrl_q[ebh_pkg::PORT_HOLD_ACK_BIT];
    // request only counts with pins in control mode and clock running
    assign hold_want = hsync.hold_req & pins_ctrl
        & ~i_pwr_stop_idle;
    assign acc = i_avs_read | i_avs_write;

    always_comb begin
        status = 16'h0000;
        status[ebh_pkg::ST_HOLD_BIT] = (st_q == ebh_pkg::EBH_ST_HOLD);
        status[ebh_pkg::ST_BUSY_BIT] = (st_q == ebh_pkg::EBH_ST_CYCLE);
        status[ebh_pkg::ST_IDLE_BIT] = (st_q == ebh_pkg::EBH_ST_TIDLE);
    end

    // register file: one wait cycle on every access
    always_comb begin
        idle_ctrl_d = idle_ctrl_q;
        port_ctrl_d = port_ctrl_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        rvalid_d = acc & ~rvalid_q;
        if (acc && !rvalid_q) begin
            case (i_avs_address)
                ebh_pkg::ADDR_IDLE_CTRL: begin
                    rdata_d = idle_ctrl_q;
                    // 16-bit unit only, fixed bits forced
                    if (i_avs_write && i_avs_byteenable == 2'h3) begin
                        idle_ctrl_d = (i_avs_writedata
                            & ebh_pkg::IDLE_SEL_MASK)
                            | ebh_pkg::IDLE_FIXED_ONES;
                    end
                end
                ebh_pkg::ADDR_PORT_CTRL: begin
                    rdata_d = {14'h0000, port_ctrl_q};
                    if (i_avs_write && i_avs_byteenable[0]) begin
                        port_ctrl_d = i_avs_writedata[1:0];
                    end
                end
                ebh_pkg::ADDR_STATUS: begin
                    rdata_d = status;
                end
                default: begin
                    rdata_d = 16'h0000;
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            idle_ctrl_q <= ebh_pkg::IDLE_CTRL_RST;
            port_ctrl_q <= 2'h0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            idle_ctrl_q <= idle_ctrl_d;
            port_ctrl_q <= port_ctrl_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q <= err_d;
        end
    end

    assign o_avs_waitrequest = acc & ~rvalid_q;
    assign o_avs_readdata = rdata_q;
    assign o_avs_response_err = err_q;

    // idle state only for external reads of a selected block
    logic idle_sel;
    assign idle_sel = idle_ctrl_q[{i_req_block, 1'b1}]
        & i_req_read
        & (i_req_region == ebh_pkg::RGN_EXT);

    logic [3:0] cand;
    always_comb begin
        st_d = st_q;
        gnt_d = gnt_q;
        lock_d = lock_q;
        rmw_d = rmw_q;
        idle_need_d = idle_need_q;
        cand = i_req;
        // between rmw read and write only fetches may enter
        if (rmw_q) begin
            cand = i_req & 4'hE;
            cand[1] = i_req[1];
            cand[0] = 1'b0;
        end
        // a halted cpu issues no cycles, of the requesters only dma may start a new access; hold can still take the bus
        if (i_pwr_halt) begin
            cand = cand & 4'h1;
        end
        case (st_q)
            ebh_pkg::EBH_ST_IDLE: begin
                // hold wins unless a split or rmw sequence is locked
                if (hold_want && !lock_q && !rmw_q) begin
                    st_d = ebh_pkg::EBH_ST_FLOAT;
                end else if (lock_q) begin
                    // split access: same master, no fetch, no hold
                    if (|(i_req & gnt_q)) begin
                        st_d = ebh_pkg::EBH_ST_CYCLE;
                        lock_d = |(i_req_lock & gnt_q);
                        idle_need_d = idle_sel;
                    end
                end else if (|cand) begin
                    gnt_d = pick(cand);
                    st_d = ebh_pkg::EBH_ST_CYCLE;
                    lock_d = |(i_req_lock & pick(cand));
                    // the rmw read is an operand access
                    if (i_req_rmw_read && pick(cand) == 4'h2) begin
                        rmw_d = 1'b1;
                    end else if (pick(cand) == 4'h2 && rmw_q) begin
                        rmw_d = 1'b0;
                    end
                    idle_need_d = idle_sel;
                end
            end
            ebh_pkg::EBH_ST_CYCLE: begin
                if (i_cycle_done) begin
                    st_d = idle_need_q ? ebh_pkg::EBH_ST_TIDLE
                        : ebh_pkg::EBH_ST_IDLE;
                    gnt_d = lock_q ? gnt_q : 4'h0;
                    // idle demand is spent once the cycle ends
                    idle_need_d = 1'b0;
                end
            end
            ebh_pkg::EBH_ST_TIDLE: begin
                st_d = ebh_pkg::EBH_ST_IDLE;
            end
            ebh_pkg::EBH_ST_FLOAT: begin
                // bus floated this cycle, acknowledge next
                st_d = ebh_pkg::EBH_ST_HOLD;
            end
            ebh_pkg::EBH_ST_HOLD: begin
                // halt also exits here: ack simply follows request
                if (!hold_want) begin
                    st_d = ebh_pkg::EBH_ST_IDLE;
                end
            end
            default: begin
                st_d = ebh_pkg::EBH_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q <= ebh_pkg::EBH_ST_IDLE;
            gnt_q <= 4'h0;
            lock_q <= 1'b0;
            rmw_q <= 1'b0;
            idle_need_q <= 1'b0;
        end else begin
            st_q <= st_d;
            gnt_q <= gnt_d;
            lock_q <= lock_d;
            rmw_q <= rmw_d;
            idle_need_q <= idle_need_d;
        end
    end

    // requesters of every region stall while hold owns the bus
    assign o_gnt = (st_q == ebh_pkg::EBH_ST_CYCLE) ? gnt_q : 4'h0;
    assign o_cycle_idle_state = (st_q == ebh_pkg::EBH_ST_TIDLE);
    assign o_bus_oe = ~((st_q == ebh_pkg::EBH_ST_FLOAT)
        | (st_q == ebh_pkg::EBH_ST_HOLD));
    assign o_hold_acknowledge_n = ~(st_q == ebh_pkg::EBH_ST_HOLD);
    assign o_hold_acknowledge_oe = pins_ctrl;

    // assertions
    chk_ack_after_float: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(o_hold_acknowledge_n) |-> $past(!o_bus_oe))
        else $error("ack asserted without a floated bus first");
    chk_hold_release: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ebh_pkg::EBH_ST_HOLD && !hold_want)
        |=> o_bus_oe && o_hold_acknowledge_n)
        else $error("hold not released after request removed");
    chk_no_hold_stop: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_pwr_stop_idle && st_q == ebh_pkg::EBH_ST_IDLE)
        |=> st_q != ebh_pkg::EBH_ST_FLOAT)
        else $error("hold entered in stop or idle mode");
    chk_pins_ctrl: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !pins_ctrl && st_q == ebh_pkg::EBH_ST_IDLE
        |=> st_q != ebh_pkg::EBH_ST_FLOAT)
        else $error("hold taken with pins in port mode");
    chk_no_hold_lock: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        lock_q |=> st_q != ebh_pkg::EBH_ST_FLOAT)
        else $error("hold granted inside a split access");
    chk_no_hold_rmw: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        rmw_q |=> st_q != ebh_pkg::EBH_ST_FLOAT)
        else $error("hold granted inside read-modify-write");
    chk_idle_reset: assert property (
        @(posedge i_clk_sys) $rose(i_rst_n) |->
        idle_ctrl_q == ebh_pkg::IDLE_CTRL_RST)
        else $error("idle control reset value wrong");
    chk_dma_first: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ebh_pkg::EBH_ST_IDLE && !lock_q && !rmw_q && !hold_want
        && i_req[0]) |=> gnt_q == 4'h1)
        else $error("dma did not win over cpu requests");
    chk_no_idle_write: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ebh_pkg::EBH_ST_IDLE && !i_req_read && !hold_want)
        |=> !idle_need_q)
        else $error("idle state armed for a write");
endmodule
`default_nettype wire

//--- hdl/ebh_hold_sync.sv
// two flip-flop synchroniser for the external hold request pin
// assumes the pin is asynchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module ebh_hold_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_hold_request_n,
    ebh_sync_if.src sync
);
    logic meta_q;
    logic meta_d;
    logic stab_q;
    logic stab_d;
    always_comb begin
        meta_d = ~i_hold_request_n;
        stab_d = meta_q;
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            stab_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end
    assign sync.hold_req = stab_q;
endmodule
`default_nettype wire

//--- hdl/ebh_pkg.sv
// package for the external bus hold arbiter
// assumes a single 25 MHz system clock domain
package ebh_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned REG_W = 16;
    localparam int unsigned NUM_BLOCKS = 4;
    // avalon word addresses of the register file
    localparam logic [1:0] ADDR_IDLE_CTRL = 2'h0;
    localparam logic [1:0] ADDR_PORT_CTRL = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [REG_W-1:0] IDLE_CTRL_RST = 16'hAAAA;
    // writable idle select bits are the odd positions 1,3,5,7
    localparam logic [REG_W-1:0] IDLE_SEL_MASK = 16'h00AA;
    // bits 15,13,11,9 read as one, other fixed bits as zero
    localparam logic [REG_W-1:0] IDLE_FIXED_ONES = 16'hAA00;
    localparam int unsigned PORT_HOLD_REQ_BIT = 0;
    localparam int unsigned PORT_HOLD_ACK_BIT = 1;
    // status bit positions
    localparam int unsigned ST_HOLD_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 1;
    localparam int unsigned ST_IDLE_BIT = 2;
    // requester indices, highest priority first
    typedef enum logic [2:0] {
        EBH_SRC_NONE = 3'h0,
        EBH_SRC_DMA = 3'h1,
        EBH_SRC_OPND = 3'h2,
        EBH_SRC_BRFETCH = 3'h3,
        EBH_SRC_SQFETCH = 3'h4
    } ebh_src_e;
    typedef enum logic [2:0] {
        EBH_ST_IDLE = 3'h0,
        EBH_ST_CYCLE = 3'h1,
        EBH_ST_TIDLE = 3'h2,
        EBH_ST_FLOAT = 3'h3,
        EBH_ST_HOLD = 3'h4
    } ebh_state_e;
    // region codes of an access
    localparam logic [1:0] RGN_INT_ROM = 2'h0;
    localparam logic [1:0] RGN_INT_RAM = 2'h1;
    localparam logic [1:0] RGN_PERIPH = 2'h2;
    localparam logic [1:0] RGN_EXT = 2'h3;
endpackage

//--- hdl/ebh_sync_if.sv
// interface carrying the synchronised hold request to the arbiter
// assumes both ends run on the system clock
`timescale 1ns/1ps
`default_nettype none
interface ebh_sync_if;
    logic hold_req;
    modport src (output hold_req);
    modport dst (input hold_req);
endinterface
`default_nettype wire

//--- verif/ebh_master_model.sv
// model of the outside bus master that borrows the external bus
// assumes the system clock and the arbiter's hold pins
`timescale 1ns/1ps
`default_nettype none
module ebh_master_model (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_want,
    input wire logic i_slow,
    input wire logic i_hold_acknowledge_n,
    input wire logic i_bus_oe,
    output logic o_hold_request_n,
    output logic o_fault
);
    logic req_q, req_d, own_q, own_d, flt_q, flt_d;
    logic [1:0] cnt_q, cnt_d;
    always_comb begin
        req_d = req_q;
        own_d = own_q;
        cnt_d = (i_want && !req_q) ? cnt_q + 2'h1 : 2'h0;
        // acknowledge while the bus is still driven is a clash
        flt_d = flt_q | (!i_hold_acknowledge_n & i_bus_oe);
        if (!req_q && !own_q && i_want && (!i_slow || cnt_q == 2'h3)) begin
            req_d = 1'b1;
        end
        // request stays asserted until the acknowledge is seen and i_want drops
        if (req_q && !i_hold_acknowledge_n) begin
            own_d = 1'b1;
        end
        if (own_q && !i_want) begin
            req_d = 1'b0;
        end
        if (!req_q && i_hold_acknowledge_n) begin
            own_d = 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            req_q <= 1'b0;
            own_q <= 1'b0;
            flt_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            req_q <= req_d;
            own_q <= own_d;
            flt_q <= flt_d;
            cnt_q <= cnt_d;
        end
    end
    assign o_hold_request_n = !req_q;
    assign o_fault = flt_q;
endmodule
`default_nettype wire

//--- verif/external_bus_hold_arbiter_test.sv
// self-checking bench for the external bus hold arbiter
// assumes the arbiter top and the outside master model
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_arbiter_test;
    typedef struct packed {
        logic [3:0] req;
        logic rd;
        logic [1:0] rgn;
        logic [1:0] blk;
        logic [3:0] gnt;
        logic idle;
    } ebh_row_s;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, stop = 0, halt = 0;
    logic want = 0, slow = 0, rmw = 0, rdacc = 0, done = 0;
    logic [1:0] addr = 0, be = 2'h3, rgn = 0, blk = 0;
    logic [15:0] wdata = 0, rdata;
    logic [3:0] req = 0, lock = 0, gnt;
    logic wreq, err, ack_n, ack_oe, bus_oe, hreq_n, fault, idle;
    int err_count = 0, samples_checked = 0;
    always #20 clk = ~clk;
    ebh_arbiter i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_byteenable(be), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .o_avs_response_err(err), .i_hold_request_n(hreq_n),
        .o_hold_acknowledge_n(ack_n), .o_hold_acknowledge_oe(ack_oe),
        .o_bus_oe(bus_oe), .i_pwr_stop_idle(stop), .i_pwr_halt(halt),
        .i_req(req), .i_req_lock(lock), .i_req_rmw_read(rmw),
        .i_req_read(rdacc), .i_req_region(rgn), .i_req_block(blk),
        .o_gnt(gnt), .o_cycle_idle_state(idle), .i_cycle_done(done));
    ebh_master_model i_master (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_want(want), .i_slow(slow), .i_hold_acknowledge_n(ack_n),
        .i_bus_oe(bus_oe), .o_hold_request_n(hreq_n), .o_fault(fault));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task av(input logic w, input logic [1:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= d;
        // request holds until the edge that sees waitrequest low
        do begin
            @(negedge clk);
            q = rdata;
            e = err;
        end while (wreq !== 1'b0);
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // sel 0: acknowledge low, 1: acknowledge high, 2: any grant
    task wait_for(input int sel, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!((sel == 0 && ack_n === 1'b0) || (sel == 1 &&
            ack_n === 1'b1) || (sel == 2 && gnt !== 4'h0)) && n < lim);
        chk({15'h0, n < lim}, 16'h1);
    endtask
    task stay(input logic [4:0] e, input int k);
        repeat (k) begin
            @(negedge clk);
            chk({11'h0, ack_n, gnt}, {11'h0, e});
        end
    endtask
    task cyc(input logic [3:0] r, input logic [3:0] lk, input logic rm,
             input logic keep, output logic [3:0] g, output int ic);
        @(posedge clk);
        req <= r;
        lock <= lk;
        rmw <= rm;
        wait_for(2, 20);
        g = gnt;
        ic = 0;
        @(posedge clk);
        done <= 1'b1;
        if (!keep) req <= 4'h0;
        repeat (5) begin
            @(negedge clk);
            ic += idle;
            @(posedge clk);
            done <= 1'b0;
        end
    endtask
    // split or read-modify-write pair, hold wanted in the middle
    task locked(input logic rm);
        logic [3:0] g, r;
        int ic;
        r = rm ? 4'h2 : 4'h1;
        @(posedge clk);
        req <= r;
        lock <= rm ? 4'h0 : 4'h1;
        rmw <= rm;
        rdacc <= 1'b1;
        wait_for(2, 20);
        @(posedge clk);
        want <= 1'b1;
        stay({1'b1, r}, 6);
        // second part is the last split part or the rmw write
        cyc(r, 4'h0, 1'b0, 1'b1, g, ic);
        chk({11'h0, ack_n, gnt}, {11'h0, 1'b1, r});
        rdacc <= !rm;
        cyc(r, 4'h0, 1'b0, 1'b0, g, ic);
        wait_for(0, 12);
        @(posedge clk);
        req <= r;
        stay(5'h00, 5);
        @(posedge clk);
        want <= 1'b0;
        cyc(r, 4'h0, 1'b0, 1'b0, g, ic);
        chk({12'h0, g}, {12'h0, r});
    endtask
    initial begin
        ebh_row_s rows [8];
        logic [15:0] q;
        logic e;
        logic [3:0] g;
        int ic;
        rows = '{'{4'hF, 1'b1, 2'h3, 2'h0, 4'h1, 1'b1},
            '{4'hE, 1'b1, 2'h3, 2'h1, 4'h2, 1'b1},
            '{4'hC, 1'b1, 2'h3, 2'h2, 4'h4, 1'b0},
            '{4'h8, 1'b1, 2'h3, 2'h3, 4'h8, 1'b0},
            '{4'hA, 1'b0, 2'h3, 2'h0, 4'h2, 1'b0},
            '{4'h1, 1'b1, 2'h0, 2'h0, 4'h1, 1'b0},
            '{4'h1, 1'b1, 2'h1, 2'h0, 4'h1, 1'b0},
            '{4'h1, 1'b1, 2'h2, 2'h1, 4'h1, 1'b0}};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        av(1'b0, 2'h0, 16'h0, q, e);
        chk(q, 16'hAAAA);
        av(1'b1, 2'h0, 16'hAA0A, q, e);
        av(1'b0, 2'h0, 16'h0, q, e);
        chk(q, 16'hAA0A);
        foreach (rows[i]) begin
            rdacc <= rows[i].rd;
            rgn <= rows[i].rgn;
            blk <= rows[i].blk;
            cyc(rows[i].req, 4'h0, 1'b0, 1'b0, g, ic);
            chk({12'h0, g}, {12'h0, rows[i].gnt});
            chk({15'h0, ic != 0}, {15'h0, rows[i].idle});
        end
        av(1'b0, 2'h3, 16'h0, q, e);
        chk({e, q[14:0]}, 16'h8000);
        want <= 1'b1;
        stay(5'h10, 10);
        chk({15'h0, ack_oe}, 16'h0);
        av(1'b1, 2'h1, 16'h0003, q, e);
        wait_for(0, 12);
        chk({14'h0, bus_oe, ack_oe}, 16'h1);
        @(posedge clk);
        want <= 1'b0;
        wait_for(1, 12);
        repeat (2) @(negedge clk);
        chk({15'h0, bus_oe}, 16'h1);
        locked(1'b0);
        locked(1'b1);
        @(posedge clk);
        stop <= 1'b1;
        want <= 1'b1;
        stay(5'h10, 10);
        @(posedge clk);
        stop <= 1'b0;
        wait_for(0, 12);
        @(posedge clk);
        want <= 1'b0;
        wait_for(1, 12);
        @(posedge clk);
        halt <= 1'b1;
        slow <= 1'b1;
        want <= 1'b1;
        wait_for(0, 16);
        @(posedge clk);
        want <= 1'b0;
        wait_for(1, 12);
        chk({15'h0, fault}, 16'h0);
        finish_test;
    end
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        finish_test;
    end
endmodule
`default_nettype wire
